// [adc_out_pkg.sv]
// Package with constants and carrier types for the converter output stage.
package adc_out_pkg;

  // ==========================================================================
  // Sample word and latency
  // ==========================================================================
  // Bits per sample on each channel.
  localparam int SAMPLE_W = 12;
  // Number of differential pairs per channel in double-data-rate mode.
  localparam int PAIR_N = 6;
  // Latency in sampling clock cycles for the normal path.
  localparam int LAT_NORMAL = 14;
  // Latency in sampling clock cycles with the processing path bypassed.
  localparam int LAT_LOW = 10;

  // ==========================================================================
  // Overdrive clamp codes
  // ==========================================================================
  localparam logic [11:0] OB_POS_CLAMP = 12'h7ff;
  localparam logic [11:0] TC_POS_CLAMP = 12'h3ff;
  localparam logic [11:0] OB_NEG_CLAMP = 12'h000;
  localparam logic [11:0] TC_NEG_CLAMP = 12'h400;
  // Offset binary midscale code.
  localparam logic [11:0] MIDSCALE = 12'h800;

  // ==========================================================================
  // Power-down mode field and loop time constant codes
  // ==========================================================================
  localparam logic [2:0] PDN_MUX = 3'h7;
  localparam logic [2:0] TAU_2P27 = 3'h0;
  localparam logic [2:0] TAU_2P26 = 3'h1;
  localparam logic [2:0] TAU_2P25 = 3'h2;
  localparam logic [2:0] TAU_2P24 = 3'h3;
  localparam logic [2:0] TAU_2P28 = 3'h4;
  localparam logic [2:0] TAU_2P29 = 3'h5;

  // ==========================================================================
  // Register map: word offsets on the plain register port
  // ==========================================================================
  localparam logic [3:0] REG_IFACE = 4'h0;
  localparam logic [3:0] REG_DRIVE = 4'h1;
  localparam logic [3:0] REG_LOOP = 4'h2;
  localparam logic [3:0] REG_OFS_A = 4'h3;
  localparam logic [3:0] REG_OFS_B = 4'h4;

  // Interface register field positions.
  localparam int BIT_DDR = 0;
  localparam int BIT_TWOS = 1;
  localparam int BIT_LOWLAT = 2;
  localparam int BIT_PINCFG = 3;
  localparam int POS_PDN = 4;
  // Drive register field positions.
  localparam int POS_CURR = 0;
  localparam int BIT_CDBL = 2;
  localparam int POS_TERM = 3;
  localparam int BIT_DSTR = 6;
  localparam int BIT_CSTR = 7;
  // Loop register field positions.
  localparam int BIT_LOOP_EN = 0;
  localparam int BIT_FREEZE = 1;
  localparam int POS_TAU = 4;

  // Reset values.
  localparam logic [15:0] IFACE_RST = 16'h0000;
  localparam logic [15:0] DRIVE_RST = 16'h0000;
  localparam logic [15:0] LOOP_RST = 16'h0000;

  // Accumulator width: sign, sample and fraction bits for the slowest constant.
  localparam int ACC_W = 42;
  localparam int FRAC_W = 29;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  // One raw sample pair from the converter core.
  typedef struct packed {
    logic [11:0] chan_a;
    logic [11:0] chan_b;
    logic [1:0] over_pos;
    logic [1:0] over_neg;
  } raw_pair_t;

  // Drive settings presented to the analog output buffers.
  typedef struct packed {
    logic [1:0] diff_current;
    logic current_double;
    logic [2:0] termination;
    logic data_drive_level;
    logic clock_drive_level;
  } drive_cfg_t;

  // One channel's pin group: value and output enables.
  typedef struct packed {
    logic [11:0] data_o;
    logic [11:0] data_oe;
  } pin_bus_t;

endpackage : adc_out_pkg

// [adc_output_port_offset_loop.sv]
// Output stage of a dual 12-bit converter with its dc offset loop.
`timescale 1ns/1ps

// Contract
// - 12-bit word per channel, shared clock.
// - Select single-ended or DDR by bit/pin.
// - Single-ended: one pin per bit, per cycle.
// - DDR: two bits per pair, six pairs.
// - Even bits on rise, odd on fall.
// - Differential current setting, default 3.5 mA.
// - Current double for data and clock.
// - Three termination resistors, any combination.
// - Stronger data and clock drive settings.
// - Twos complement or offset binary, bit/pin.
// - Positive overdrive clamps 0x7FF or 0x3FF.
// - Negative overdrive clamps 0x000 or 0x400.
// - Multiplex only single-ended, on bus B.
// - Multiplexing tri-states channel A pins.
// - Multiplex via mode field or pins.
// - Code 111 or pins high selects multiplex.
// - Latency 14 cycles, 10 in low latency.
// - Low latency bypasses offset correction.
// - Enabled loop subtracts offset every cycle.
// - Time constant code selects 2^24..2^29.
// - Freeze holds and applies last estimate.
// - Offset correction off after reset.
module adc_output_port_offset_loop (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Raw samples from the converter core.
  input wire adc_out_pkg::raw_pair_t raw_in,
  // Configuration pins, asynchronous to clk_sys.
  input wire logic serial_enable_pin,
  input wire logic ctl_pin_1,
  input wire logic ctl_pin_2,
  input wire logic ctl_pin_3,
  // Plain register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Output pins.
  output adc_out_pkg::pin_bus_t chan_a_bus,
  output adc_out_pkg::pin_bus_t chan_b_bus,
  output logic fwd_clock_se,
  output logic fwd_clock_diff_pos,
  output logic ddr_mode,
  output adc_out_pkg::drive_cfg_t drive_cfg
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Two-stage synchronisers for the four configuration pins.
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s1_nxt;
  logic [3:0] pin_s2_nxt;

  // First stage feeds only the second stage.
  always_comb begin
    pin_s1_nxt = {ctl_pin_3, ctl_pin_2, ctl_pin_1, serial_enable_pin};
    pin_s2_nxt = pin_s1_r;
  end

  // Synchroniser registers advance only on cycles with clk_en high.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else if (clk_en) begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [15:0] iface_r;
  logic [15:0] drive_r;
  logic [15:0] loop_r;
  logic [15:0] reg_rdata_r;
  logic [15:0] iface_nxt;
  logic [15:0] drive_nxt;
  logic [15:0] loop_nxt;
  logic [15:0] reg_rdata_nxt;
  // Offset estimates, read back for software inspection.
  logic signed [adc_out_pkg::ACC_W-1:0] acc_a_r;
  logic signed [adc_out_pkg::ACC_W-1:0] acc_b_r;
  logic signed [11:0] est_a;
  logic signed [11:0] est_b;

  assign est_a = acc_a_r[adc_out_pkg::FRAC_W +: 12];
  assign est_b = acc_b_r[adc_out_pkg::FRAC_W +: 12];

  // Register writes and the one-cycle-late read data.
  always_comb begin
    iface_nxt = iface_r;
    drive_nxt = drive_r;
    loop_nxt = loop_r;
    reg_rdata_nxt = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        adc_out_pkg::REG_IFACE: iface_nxt = reg_wdata;
        adc_out_pkg::REG_DRIVE: drive_nxt = reg_wdata;
        adc_out_pkg::REG_LOOP: loop_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      // Unmapped addresses read as zero.
      case (reg_addr)
        adc_out_pkg::REG_IFACE: reg_rdata_nxt = iface_r;
        adc_out_pkg::REG_DRIVE: reg_rdata_nxt = drive_r;
        adc_out_pkg::REG_LOOP: reg_rdata_nxt = loop_r;
        adc_out_pkg::REG_OFS_A: reg_rdata_nxt = {{4{est_a[11]}}, est_a};
        adc_out_pkg::REG_OFS_B: reg_rdata_nxt = {{4{est_b[11]}}, est_b};
        default: reg_rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Loop enable resets cleared, so correction stays off until written.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iface_r <= adc_out_pkg::IFACE_RST;
      drive_r <= adc_out_pkg::DRIVE_RST;
      loop_r <= adc_out_pkg::LOOP_RST;
      reg_rdata_r <= 16'h0000;
    end else if (clk_en) begin
      iface_r <= iface_nxt;
      drive_r <= drive_nxt;
      loop_r <= loop_nxt;
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  logic pin_cfg;
  logic sel_ddr;
  logic sel_twos;
  logic low_lat;
  logic mux_req;
  logic mux_on;
  logic loop_en;
  logic loop_freeze;
  logic [2:0] tau_code;

  // In pin mode the serial enable pin picks both interface and format.
  always_comb begin
    pin_cfg = iface_r[adc_out_pkg::BIT_PINCFG];
    sel_ddr = pin_cfg ? pin_s2_r[0] : iface_r[adc_out_pkg::BIT_DDR];
    sel_twos = pin_cfg ? pin_s2_r[0] : iface_r[adc_out_pkg::BIT_TWOS];
    low_lat = iface_r[adc_out_pkg::BIT_LOWLAT];
    mux_req = pin_cfg ? (pin_s2_r[3:1] == 3'h7)
                      : (iface_r[adc_out_pkg::POS_PDN +: 3] == adc_out_pkg::PDN_MUX);
    mux_on = mux_req && !sel_ddr;
    loop_en = loop_r[adc_out_pkg::BIT_LOOP_EN] && !low_lat;
    loop_freeze = loop_r[adc_out_pkg::BIT_FREEZE];
    tau_code = loop_r[adc_out_pkg::POS_TAU +: 3];
  end

  // Buffer settings: code 0 is the 3.5 mA default, the rest the others.
  always_comb begin
    drive_cfg.diff_current = drive_r[adc_out_pkg::POS_CURR +: 2];
    drive_cfg.current_double = drive_r[adc_out_pkg::BIT_CDBL];
    drive_cfg.termination = drive_r[adc_out_pkg::POS_TERM +: 3];
    drive_cfg.data_drive_level = drive_r[adc_out_pkg::BIT_DSTR];
    drive_cfg.clock_drive_level = drive_r[adc_out_pkg::BIT_CSTR];
  end

  assign ddr_mode = sel_ddr;

  // ==========================================================================
  // Offset loop
  // ==========================================================================
  // The estimate is a leaky integrator whose shift sets the time constant.
  logic signed [adc_out_pkg::ACC_W-1:0] acc_a_nxt;
  logic signed [adc_out_pkg::ACC_W-1:0] acc_b_nxt;
  logic [4:0] shift;
  logic signed [12:0] err_a;
  logic signed [12:0] err_b;
  logic [11:0] cor_a;
  logic [11:0] cor_b;
  // Width to which the error is extended before it is shifted.
  localparam int ACC_EXT = adc_out_pkg::ACC_W;

  // Decode the time constant: unused codes fall back to 2^27.
  always_comb begin
    case (tau_code)
      adc_out_pkg::TAU_2P26: shift = 5'h1a;
      adc_out_pkg::TAU_2P25: shift = 5'h19;
      adc_out_pkg::TAU_2P24: shift = 5'h18;
      adc_out_pkg::TAU_2P28: shift = 5'h1c;
      adc_out_pkg::TAU_2P29: shift = 5'h1d;
      default: shift = 5'h1b;
    endcase
  end

  // Error is the corrected signed sample; integrating it drives it to zero.
  always_comb begin
    err_a = 13'(signed'({1'b0, raw_in.chan_a} - {1'b0, adc_out_pkg::MIDSCALE}))
            - 13'(est_a);
    err_b = 13'(signed'({1'b0, raw_in.chan_b} - {1'b0, adc_out_pkg::MIDSCALE}))
            - 13'(est_b);
    acc_a_nxt = acc_a_r;
    acc_b_nxt = acc_b_r;
    if (loop_en && !loop_freeze) begin
      acc_a_nxt = acc_a_r + ((ACC_EXT'(err_a) <<< adc_out_pkg::FRAC_W) >>> shift);
      acc_b_nxt = acc_b_r + ((ACC_EXT'(err_b) <<< adc_out_pkg::FRAC_W) >>> shift);
    end
    // Subtract the held estimate whenever the loop is enabled.
    cor_a = loop_en ? raw_in.chan_a - 12'(est_a) : raw_in.chan_a;
    cor_b = loop_en ? raw_in.chan_b - 12'(est_b) : raw_in.chan_b;
  end

  // The estimate clears at reset so the loop starts from zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_a_r <= '0;
      acc_b_r <= '0;
    end else if (clk_en) begin
      acc_a_r <= acc_a_nxt;
      acc_b_r <= acc_b_nxt;
    end
  end

  // ==========================================================================
  // Format, overdrive and latency pipeline
  // ==========================================================================
  // Delay line long enough for the default latency; a tap selects depth.
  logic [23:0] pipe_r [adc_out_pkg::LAT_NORMAL];
  logic [23:0] pipe_nxt [adc_out_pkg::LAT_NORMAL];
  logic [11:0] fmt_a;
  logic [11:0] fmt_b;
  logic [23:0] tap;

  // Overdrive clamps take the place of the corrected code.
  always_comb begin
    if (raw_in.over_pos[1]) begin
      fmt_a = sel_twos ? adc_out_pkg::TC_POS_CLAMP : adc_out_pkg::OB_POS_CLAMP;
    end else if (raw_in.over_neg[1]) begin
      fmt_a = sel_twos ? adc_out_pkg::TC_NEG_CLAMP : adc_out_pkg::OB_NEG_CLAMP;
    end else begin
      fmt_a = {cor_a[11] ^ sel_twos, cor_a[10:0]};
    end
    if (raw_in.over_pos[0]) begin
      fmt_b = sel_twos ? adc_out_pkg::TC_POS_CLAMP : adc_out_pkg::OB_POS_CLAMP;
    end else if (raw_in.over_neg[0]) begin
      fmt_b = sel_twos ? adc_out_pkg::TC_NEG_CLAMP : adc_out_pkg::OB_NEG_CLAMP;
    end else begin
      fmt_b = {cor_b[11] ^ sel_twos, cor_b[10:0]};
    end
    pipe_nxt[0] = {fmt_a, fmt_b};
    for (int i = 1; i < adc_out_pkg::LAT_NORMAL; i++) begin
      pipe_nxt[i] = pipe_r[i-1];
    end
    // Capture is cycle 0; the output register adds the last cycle.
    tap = low_lat ? pipe_r[adc_out_pkg::LAT_LOW-2]
                  : pipe_r[adc_out_pkg::LAT_NORMAL-2];
  end

  // Pipeline shift; data need no reset but one keeps outputs defined.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < adc_out_pkg::LAT_NORMAL; i++) begin
        pipe_r[i] <= 24'h000000;
      end
    end else if (clk_en) begin
      pipe_r <= pipe_nxt;
    end
  end

  // ==========================================================================
  // Output drive
  // ==========================================================================
  // Multiplex sequencing alternates channel A then B on bus B.
  logic mux_ph_r;
  logic mux_ph_nxt;
  logic [11:0] out_a_r;
  logic [11:0] out_b_r;
  logic [11:0] out_a_nxt;
  logic [11:0] out_b_nxt;
  logic clk_ph_r;
  logic clk_ph_nxt;

  // The forwarded clock is one toggle per cycle; a bench sees its level.
  // Limitation: true DDR edges need the pad clock; here the phase marks
  // the half in which even bits stand on the pairs.
  always_comb begin
    mux_ph_nxt = mux_on ? !mux_ph_r : 1'b0;
    clk_ph_nxt = !clk_ph_r;
    out_a_nxt = tap[23:12];
    out_b_nxt = tap[11:0];
    if (mux_on) begin
      out_b_nxt = mux_ph_r ? out_b_r : tap[23:12];
      out_b_nxt = mux_ph_r ? tap[11:0] : out_b_nxt;
    end
  end

  // Output registers hold the current words.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mux_ph_r <= 1'b0;
      clk_ph_r <= 1'b0;
      out_a_r <= 12'h000;
      out_b_r <= 12'h000;
    end else if (clk_en) begin
      mux_ph_r <= mux_ph_nxt;
      clk_ph_r <= clk_ph_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
    end
  end

  // Pin mapping. In DDR mode pair k carries bit 2k on the rising phase
  // and bit 2k+1 on the falling phase; upper pins go quiet.
  always_comb begin
    chan_a_bus.data_o = out_a_r;
    chan_b_bus.data_o = out_b_r;
    chan_a_bus.data_oe = mux_on ? 12'h000 : 12'hfff;
    chan_b_bus.data_oe = 12'hfff;
    if (sel_ddr) begin
      for (int k = 0; k < adc_out_pkg::PAIR_N; k++) begin
        chan_a_bus.data_o[k] = out_a_r[2*k + (clk_ph_r ? 0 : 1)];
        chan_b_bus.data_o[k] = out_b_r[2*k + (clk_ph_r ? 0 : 1)];
      end
      chan_a_bus.data_o[11:6] = 6'h00;
      chan_b_bus.data_o[11:6] = 6'h00;
      chan_a_bus.data_oe = 12'h03f;
      chan_b_bus.data_oe = 12'h03f;
    end
    fwd_clock_se = sel_ddr ? 1'b0 : clk_ph_r;
    fwd_clock_diff_pos = sel_ddr ? clk_ph_r : 1'b0;
  end

endmodule : adc_output_port_offset_loop

// [adc_out_chk.sv]
// Concurrent checks on the ports of the converter output stage.
`timescale 1ns/1ps
module adc_out_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_enable_pin,
  input wire logic ctl_pin_1,
  input wire logic ctl_pin_2,
  input wire logic ctl_pin_3,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire adc_out_pkg::pin_bus_t chan_a_bus,
  input wire logic fwd_clock_se,
  input wire logic fwd_clock_diff_pos,
  input wire logic ddr_mode,
  input wire adc_out_pkg::drive_cfg_t drive_cfg
);
  // ==========================================================================
  // Shadow state
  // ==========================================================================
  logic [15:0] iface_r; // Copy of the interface register.
  logic [7:0] drive_r; // Copy of the drive register.
  logic loop_seen_r; // Set once the loop has been enabled since reset.
  logic ddr_sel; // Interface that the design should settle on.
  logic mux_sel; // Multiplexed output should be active.
  // Mirror accepted writes, so no check has to look inside the body.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iface_r <= 16'h0000;
      drive_r <= 8'h00;
      loop_seen_r <= 1'b0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == 4'h0) iface_r <= reg_wdata;
      if (reg_addr == 4'h1) drive_r <= reg_wdata[7:0];
      if (reg_addr == 4'h2 && reg_wdata[0]) loop_seen_r <= 1'b1;
    end
  end
  // Pin mode hands both choices to the pins, which resynchronise later.
  assign ddr_sel = iface_r[3] ? serial_enable_pin : iface_r[0];
  assign mux_sel = !ddr_sel && (iface_r[3] ?
    (ctl_pin_1 && ctl_pin_2 && ctl_pin_3) : (iface_r[6:4] == 3'h7));
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  iface_read_a: assert property ($past(reg_rd && clk_en &&
    reg_addr == 4'h0) |-> reg_rdata == ($past(iface_r) & 16'h007f))
    else $error("interface register read back wrong");
  loop_off_a: assert property (!loop_seen_r && $past(reg_rd &&
    clk_en && reg_addr inside {4'h3, 4'h4}) |-> reg_rdata == 16'h0000)
    else $error("offset estimate nonzero with loop never enabled");
  drive_map_a: assert property (drive_cfg == {drive_r[1:0],
    drive_r[2], drive_r[5:3], drive_r[6], drive_r[7]})
    else $error("drive settings differ from drive register");
  se_clock_a: assert property ((!ddr_mode && clk_en)[*3] |->
    fwd_clock_se != $past(fwd_clock_se)) else $error("parallel clock stuck");
  ddr_clock_a: assert property ((ddr_mode && clk_en)[*3] |->
    !fwd_clock_se && fwd_clock_diff_pos != $past(fwd_clock_diff_pos))
    else $error("double rate clock wrong");
  se_quiet_a: assert property ((!ddr_mode)[*3] |->
    !fwd_clock_diff_pos) else $error("differential clock runs in parallel");
  mux_tristate_a: assert property ($rose(mux_sel) |->
    ##[1:20] chan_a_bus.data_oe == 12'h000)
    else $error("channel A pins still driven in multiplexed mode");
  ddr_follow_a: assert property ($changed(ddr_sel) |->
    ##[1:4] ddr_mode == ddr_sel) else $error("interface select not taken");
endmodule : adc_out_chk

bind adc_output_port_offset_loop adc_out_chk i_chk (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .serial_enable_pin(serial_enable_pin), .ctl_pin_1(ctl_pin_1),
  .ctl_pin_2(ctl_pin_2), .ctl_pin_3(ctl_pin_3), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .chan_a_bus(chan_a_bus),
  .fwd_clock_se(fwd_clock_se), .fwd_clock_diff_pos(fwd_clock_diff_pos),
  .ddr_mode(ddr_mode), .drive_cfg(drive_cfg)
);

// [adc_rx_model.sv]
// Behavioural capture receiver on the far side of the output pins.
`timescale 1ns/1ps
module adc_rx_model (
  input wire logic fwd_clock_se,
  input wire logic fwd_clock_diff_pos,
  input wire logic [11:0] pins,
  output logic [11:0] se_word,
  output logic [11:0] ddr_word
);
  // ==========================================================================
  // Capture
  // ==========================================================================
  logic [5:0] even_r; // Even bits taken after the last rising edge.
  // Parallel mode: one whole word on each rising forwarded clock edge.
  always @(posedge fwd_clock_se) begin
    se_word <= pins;
  end
  // The pair mux follows the clock phase, so look a little after the edge.
  always @(posedge fwd_clock_diff_pos) begin
    #1 even_r = pins[5:0];
  end
  // The falling edge completes the word from the odd bits.
  always @(negedge fwd_clock_diff_pos) begin
    #1;
    for (int k = 0; k < 6; k++) begin
      ddr_word[2 * k] = even_r[k];
      ddr_word[2 * k + 1] = pins[k];
    end
  end
endmodule : adc_rx_model

// [adc_output_port_offset_loop_tb.sv]
// Self-checking bench for the converter output stage.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp=%h got=%h", n, e, a); end end
module adc_output_port_offset_loop_tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  typedef struct {int due; int kind; logic [15:0] exp;} note_t;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic clk_en = 1'b1; // Dropped once to show that a write is lost.
  adc_out_pkg::raw_pair_t raw_in = '0; // Samples from the core.
  logic serial_enable_pin = 1'b0, ctl_pin_1 = 1'b0;
  logic ctl_pin_2 = 1'b0, ctl_pin_3 = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  adc_out_pkg::pin_bus_t chan_a_bus, chan_b_bus;
  logic fwd_clock_se, fwd_clock_diff_pos, ddr_mode;
  adc_out_pkg::drive_cfg_t drive_cfg;
  logic [11:0] se_word, ddr_word, prev_b; // Receiver words; bus B delayed.
  note_t q[$]; // Expected results waiting for their cycle.
  int cyc = 0, fail_count = 0, checked = 0;
  int lat = 15; // Due offset of a sample note, in cycles.
  logic twos = 1'b0; // Format expected at the outputs.
  string nm [9] = '{"rdata", "bus_a", "bus_b", "oe_a", "ddr_mode",
    "rx_ddr", "rx_se", "mux_pair", "drive"};
  adc_output_port_offset_loop i_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .raw_in(raw_in),
    .serial_enable_pin(serial_enable_pin), .ctl_pin_1(ctl_pin_1),
    .ctl_pin_2(ctl_pin_2), .ctl_pin_3(ctl_pin_3), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan_a_bus(chan_a_bus),
    .chan_b_bus(chan_b_bus), .fwd_clock_se(fwd_clock_se),
    .fwd_clock_diff_pos(fwd_clock_diff_pos), .ddr_mode(ddr_mode),
    .drive_cfg(drive_cfg));
  adc_rx_model i_rx (.fwd_clock_se(fwd_clock_se),
    .fwd_clock_diff_pos(fwd_clock_diff_pos), .pins(chan_b_bus.data_o),
    .se_word(se_word), .ddr_word(ddr_word));
  // ==========================================================================
  // Clock, cycle count and watcher
  // ==========================================================================
  always #50 clk_sys = ~clk_sys;
  // The ceiling sits above the long offset run plus the rest, near 8900.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 10000) begin
      fail_count++;
      finish_test();
    end
  end
  // Mid-cycle the outputs are settled; every due note is compared there.
  always @(negedge clk_sys) begin
    for (int i = q.size() - 1; i >= 0; i--) begin
      if (q[i].due == cyc) begin
        `CHK(nm[q[i].kind], q[i].exp, act(q[i].kind))
        q.delete(i);
      end
    end
    prev_b = chan_b_bus.data_o;
  end
  function automatic logic [15:0] act(int k);
    logic mp;
    mp = {prev_b, chan_b_bus.data_o} inside {24'h3a5a5c, 24'ha5c3a5};
    case (k)
      0: return reg_rdata;
      1: return {4'h0, chan_a_bus.data_o};
      2: return {4'h0, chan_b_bus.data_o};
      3: return {4'h0, chan_a_bus.data_oe};
      4: return {15'h0000, ddr_mode};
      5: return {4'h0, ddr_word};
      6: return {4'h0, se_word};
      7: return {15'h0000, mp};
      default: return {8'h00, drive_cfg};
    endcase
  endfunction : act
  // Expected pin code: clamps first, otherwise straight or flipped sign.
  function automatic logic [11:0] fmt(logic [11:0] v, logic p, logic n);
    if (p) return twos ? adc_out_pkg::TC_POS_CLAMP : adc_out_pkg::OB_POS_CLAMP;
    if (n) return twos ? adc_out_pkg::TC_NEG_CLAMP : adc_out_pkg::OB_NEG_CLAMP;
    return twos ? {~v[11], v[10:0]} : v;
  endfunction : fmt
  // ==========================================================================
  // Driver tasks
  // ==========================================================================
  task automatic note(int k, logic [15:0] e, int d);
    q.push_back('{cyc + d, k, e});
  endtask : note
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    note(0, e, 2);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic smp(logic [11:0] a, logic [11:0] b, logic [1:0] p, n);
    @(posedge clk_sys);
    raw_in <= '{a, b, p, n};
    note(1, {4'h0, fmt(a, p[1], n[1])}, lat);
    note(2, {4'h0, fmt(b, p[0], n[0])}, lat);
  endtask : smp
  task automatic finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    int r;
    logic [15:0] d;
    void'($urandom(60));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, adc_out_pkg::IFACE_RST);
    rd(4'h1, adc_out_pkg::DRIVE_RST);
    rd(4'h2, adc_out_pkg::LOOP_RST);
    rd(4'h3, 16'h0000);
    rd(4'h9, 16'h0000);
    note(3, 16'h0fff, 1);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom) & 16'h00ff;
      wr(4'h1, d);
      rd(4'h1, d);
      note(8, {8'h00, d[1:0], d[2], d[5:3], d[6], d[7]}, 1);
    end
    clk_en <= 1'b0; // Frozen: this write must be lost.
    wr(4'h1, 16'h0100);
    clk_en <= 1'b1;
    rd(4'h1, d);
    // Constant offset on A, fastest constant: the estimate reaches one LSB.
    smp(12'hfff, 12'h800, 2'b00, 2'b00);
    wr(4'h2, 16'h0031);
    repeat (8400) @(posedge clk_sys);
    wr(4'h2, 16'h0033);
    rd(4'h3, 16'h0001);
    rd(4'h4, 16'h0000);
    note(1, 16'h0ffe, 1);
    // Both formats, normal and short latency; loop enable is set in the latter, where low latency bypasses it.
    for (int m = 0; m < 4; m++) begin
      twos = m[0];
      lat = m[1] ? 11 : 15;
      wr(4'h0, {13'h0000, m[1], m[0], 1'b0});
      wr(4'h2, {15'h0000, m[1]});
      repeat (20) @(posedge clk_sys);
      for (int i = 0; i < 24; i++) begin
        r = $urandom % 8;
        smp(12'($urandom), 12'($urandom), {r == 0, r == 1}, {2{r == 2}});
      end
      repeat (16) @(posedge clk_sys);
    end
    wr(4'h2, 16'h0000);
    twos = 1'b0;
    wr(4'h0, 16'h0001);
    smp(12'h3a5, 12'ha5c, 2'b00, 2'b00);
    q.delete();
    repeat (30) @(posedge clk_sys);
    note(4, 16'h0001, 1);
    note(5, 16'h0a5c, 1);
    wr(4'h0, 16'h0071);
    repeat (30) @(posedge clk_sys);
    note(3, 16'h003f, 1);
    wr(4'h0, 16'h0000);
    repeat (30) @(posedge clk_sys);
    note(6, 16'h0a5c, 1);
    wr(4'h0, 16'h0070); // Sampling clock is far below the limit.
    repeat (30) @(posedge clk_sys);
    note(3, 16'h0000, 1);
    note(7, 16'h0001, 1);
    wr(4'h0, 16'h0008);
    serial_enable_pin <= 1'b1;
    repeat (30) @(posedge clk_sys);
    note(4, 16'h0001, 1);
    note(5, 16'h025c, 1);
    serial_enable_pin <= 1'b0;
    {ctl_pin_1, ctl_pin_2, ctl_pin_3} <= 3'h7;
    repeat (30) @(posedge clk_sys);
    note(3, 16'h0000, 1);
    note(7, 16'h0001, 1);
    repeat (3) @(posedge clk_sys);
    finish_test();
  end
endmodule : adc_output_port_offset_loop_tb
